// File: src/iru_pkg.sv
// Constants shared by the infrared remote carrier unit.
// Assumes a 32-bit APB slave and byte-wide registers in the low data bits.
package iru_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CFG  = 16'h5340;
  localparam logic [15:0] IDX_PSC  = 16'h5341;
  localparam logic [15:0] IDX_CARH = 16'h5342;
  localparam logic [15:0] IDX_CARL = 16'h5343;
  localparam logic [15:0] IDX_ST   = 16'h5344;
  localparam logic [15:0] IDX_LCNT = 16'h5345;
  localparam logic [15:0] IDX_IMSK = 16'h5346;
  localparam logic [15:0] IDX_IFLG = 16'h5347;
  // Field positions
  localparam int CFG_EN_BIT   = 0;
  localparam int CFG_DIR_BIT  = 1;
  localparam int PSC_LEN_LSB  = 0;
  localparam int PSC_CAR_LSB  = 4;
  localparam int EVT_UFL_BIT  = 0;
  localparam int EVT_RISE_BIT = 1;
  localparam int EVT_FALL_BIT = 2;
  // Field widths
  localparam int SEL_W  = 4;
  localparam int CAR_W  = 6;
  localparam int CNT_W  = 8;
  localparam int EVT_W  = 3;
  localparam int PSC_W  = 14;
  // Reset values
  localparam logic [1:0]       CFG_RST  = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RST  = 4'h0;
  localparam logic [CAR_W-1:0] CAR_RST  = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST  = 3'h0;
  localparam logic [SEL_W-1:0] SEL_RSVD = 4'hf;
  localparam logic [CNT_W-1:0] CNT_WRAP = 8'hff;
endpackage

// File: src/iru_prescaler.sv
// Shared prescaler with two selectable power-of-two taps.
// Assumes one clock; taps are single-cycle tick pulses.
`timescale 1ns/10ps
`default_nettype none
module iru_prescaler #(
  parameter int W = iru_pkg::PSC_W
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     run,
  input  wire logic [iru_pkg::SEL_W-1:0] car_sel,
  input  wire logic [iru_pkg::SEL_W-1:0] len_sel,
  output logic                          car_tick,
  output logic                          len_tick
);
  logic [W-1:0] div_reg;

  // Tick when the low n bits of the divider are all ones; code 0xf never ticks
  function automatic logic tap(input logic [W-1:0] d, input logic [iru_pkg::SEL_W-1:0] s);
    logic [W-1:0] m;
    m = W'((32'h1 << s) - 32'h1);
    tap = (s != iru_pkg::SEL_RSVD) && ((d & m) == m);
  endfunction

  // Free-running divider while the unit is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= '0;
    else if (run) div_reg <= div_reg + W'(1);
    else          div_reg <= '0;
  end

  assign car_tick = run && tap(div_reg, car_sel);
  assign len_tick = run && tap(div_reg, len_sel);
endmodule // iru_prescaler
`default_nettype wire

// File: src/iru_top.sv
// Infrared remote carrier unit: APB registers, carrier, length counter, edges.
// Assumes APB with 32-bit data; ir_rx is an asynchronous pin.
// How it works
// - Configuration bit 0 enables the unit and bit 1 picks receive (1) or transmit (0), both reset to 0.
// - The prescaler byte holds a carrier clock select in the upper nibble and a length select below.
// - Select code n ticks at pclk divided by 2 to the n for 0x0 to 0xe, and 0xf is reserved.
// - A 6-bit high carrier length, reset to zero, sets the high phase in carrier clocks.
// - A 6-bit low carrier length, reset to zero, sets the low phase in carrier clocks.
// - An 8-bit read-write length counter, reset to zero, counts down on the length clock.
// - Interrupt enables sit at bit 2 falling edge, bit 1 rising edge and bit 0 underflow, reset 0.
// - Flags at the same bits set on their events and clear only when software writes a one.
// - The interrupt is asserted while a flag and its enable are both set; underflow comes from the counter.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module iru_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        ir_rx,
  output logic             ir_tx
);
  localparam int CW = iru_pkg::CAR_W;
  localparam int NW = iru_pkg::CNT_W;
  localparam int EW = iru_pkg::EVT_W;
  localparam int SW = iru_pkg::SEL_W;

  logic [1:0]    cfg_reg;
  logic [SW-1:0] car_sel_reg, len_sel_reg;
  logic [CW-1:0] carh_reg, carl_reg, cg_cnt_reg, cg_cnt_next;
  logic          cg_phase_reg, cg_phase_next;
  logic          data_reg, data_next, prev_reg;
  logic [NW-1:0] lcnt_reg, lcnt_next;
  logic [EW-1:0] imsk_reg, iflg_reg, iflg_next;
  logic [2:0]    rx_sync_reg;
  logic          rx_level_reg;
  logic          pready_reg, pslverr_reg, irq_reg, ir_tx_reg;
  logic [31:0]   prdata_reg;

  // Register index match at a word-aligned address
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[31:2] == {14'h0, idx});
  endfunction

  // Bus phase decode
  wire setup_ph = psel && !penable;
  wire wr_ok    = psel && penable && pready_reg && pwrite && !pslverr_reg;
  wire hit_cfg  = hit(paddr, iru_pkg::IDX_CFG);
  wire hit_psc  = hit(paddr, iru_pkg::IDX_PSC);
  wire hit_carh = hit(paddr, iru_pkg::IDX_CARH);
  wire hit_carl = hit(paddr, iru_pkg::IDX_CARL);
  wire hit_st   = hit(paddr, iru_pkg::IDX_ST);
  wire hit_lcnt = hit(paddr, iru_pkg::IDX_LCNT);
  wire hit_imsk = hit(paddr, iru_pkg::IDX_IMSK);
  wire hit_iflg = hit(paddr, iru_pkg::IDX_IFLG);
  wire mapped   = hit_cfg | hit_psc | hit_carh | hit_carl
                | hit_st | hit_lcnt | hit_imsk | hit_iflg;

  wire unit_enable_bit  = cfg_reg[iru_pkg::CFG_EN_BIT];
  wire direction_select = cfg_reg[iru_pkg::CFG_DIR_BIT];
  wire rx_mode = unit_enable_bit && direction_select;
  wire tx_mode = unit_enable_bit && !direction_select;

  // Read data mux; reserved bits are zero
  wire [7:0] rd_byte =
      hit_cfg  ? {6'h00, cfg_reg} :
      hit_psc  ? {car_sel_reg, len_sel_reg} :
      hit_carh ? {2'h0, carh_reg} :
      hit_carl ? {2'h0, carl_reg} :
      hit_st   ? {7'h00, data_reg} :
      hit_lcnt ? lcnt_reg :
      hit_imsk ? {5'h00, imsk_reg} :
      hit_iflg ? {5'h00, iflg_reg} : 8'h00;

  // Answer prepared in setup, shown in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      prdata_reg  <= setup_ph ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // Mask value after this edge, so the interrupt follows a mask write at once
  wire [EW-1:0] imsk_next = (wr_ok && hit_imsk) ? pwdata[EW-1:0] : imsk_reg;

  // Configuration, selects, carrier lengths and mask; upper bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= iru_pkg::CFG_RST;
      car_sel_reg <= iru_pkg::SEL_RST;
      len_sel_reg <= iru_pkg::SEL_RST;
      carh_reg    <= iru_pkg::CAR_RST;
      carl_reg    <= iru_pkg::CAR_RST;
      imsk_reg    <= iru_pkg::EVT_RST;
    end else begin
      if (wr_ok && hit_cfg)  cfg_reg <= pwdata[1:0];
      if (wr_ok && hit_psc)  begin
        car_sel_reg <= pwdata[iru_pkg::PSC_CAR_LSB +: SW];
        len_sel_reg <= pwdata[iru_pkg::PSC_LEN_LSB +: SW];
      end
      if (wr_ok && hit_carh) carh_reg <= pwdata[CW-1:0];
      if (wr_ok && hit_carl) carl_reg <= pwdata[CW-1:0];
      if (wr_ok && hit_imsk) imsk_reg <= pwdata[EW-1:0];
    end
  end

  // Shared prescaler taps
  logic car_tick, len_tick;
  iru_prescaler #(.W(iru_pkg::PSC_W)) u_psc (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (unit_enable_bit),
    .car_sel  (car_sel_reg),
    .len_sel  (len_sel_reg),
    .car_tick (car_tick),
    .len_tick (len_tick)
  );

  // Receive pin: three stages, change accepted when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_reg  <= 3'h0;
      rx_level_reg <= 1'b0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], ir_rx};
      if (rx_sync_reg[1] == rx_sync_reg[2]) rx_level_reg <= rx_sync_reg[2];
    end
  end

  // Carrier: high phase lasts length+1 ticks, then low phase likewise
  wire [CW-1:0] phase_len = cg_phase_reg ? carh_reg : carl_reg;
  always_comb begin
    cg_cnt_next   = cg_cnt_reg;
    cg_phase_next = cg_phase_reg;
    if (!tx_mode) begin
      cg_cnt_next   = '0;
      cg_phase_next = 1'b1;
    end else if (car_tick) begin
      if (cg_cnt_reg == phase_len) begin
        cg_cnt_next   = '0;
        cg_phase_next = !cg_phase_reg;
      end else begin
        cg_cnt_next = cg_cnt_reg + CW'(1);
      end
    end
  end

  // Line data bit: sampled level in receive, software value otherwise
  always_comb begin
    data_next = data_reg;
    if (rx_mode)                 data_next = rx_level_reg;
    else if (wr_ok && hit_st)    data_next = pwdata[0];
  end

  // Length counter; a software write wins over a tick
  wire ufl_evt = unit_enable_bit && len_tick && (lcnt_reg == '0);
  always_comb begin
    lcnt_next = lcnt_reg;
    if (wr_ok && hit_lcnt)       lcnt_next = pwdata[NW-1:0];
    else if (ufl_evt)            lcnt_next = iru_pkg::CNT_WRAP;
    else if (unit_enable_bit && len_tick) lcnt_next = lcnt_reg - NW'(1);
  end

  // Events: set wins over a write-one clear
  wire rise_evt = unit_enable_bit && data_reg && !prev_reg;
  wire fall_evt = unit_enable_bit && !data_reg && prev_reg;
  wire [EW-1:0] evt_set;
  assign evt_set[iru_pkg::EVT_UFL_BIT]  = ufl_evt;
  assign evt_set[iru_pkg::EVT_RISE_BIT] = rise_evt;
  assign evt_set[iru_pkg::EVT_FALL_BIT] = fall_evt;
  wire [EW-1:0] evt_clr = (wr_ok && hit_iflg) ? pwdata[EW-1:0] : '0;
  assign iflg_next = (iflg_reg & ~evt_clr) | evt_set;

  // Core state flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cg_cnt_reg   <= iru_pkg::CAR_RST;
      cg_phase_reg <= 1'b1;
      data_reg     <= 1'b0;
      prev_reg     <= 1'b0;
      lcnt_reg     <= iru_pkg::CNT_RST;
      iflg_reg     <= iru_pkg::EVT_RST;
    end else begin
      cg_cnt_reg   <= cg_cnt_next;
      cg_phase_reg <= cg_phase_next;
      data_reg     <= data_next;
      prev_reg     <= data_reg;
      lcnt_reg     <= lcnt_next;
      iflg_reg     <= iflg_next;
    end
  end

  // Registered pin and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg   <= 1'b0;
      ir_tx_reg <= 1'b0;
    end else begin
      irq_reg   <= |(iflg_next & imsk_next);
      ir_tx_reg <= tx_mode && data_reg && cg_phase_reg;
    end
  end

  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;
  assign irq     = irq_reg;
  assign ir_tx   = ir_tx_reg;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cfg_write_a: assert property (wr_ok && hit_cfg |=> cfg_reg == $past(pwdata[1:0]))
    else $error("configuration write not stored");
  psc_write_a: assert property (wr_ok && hit_psc
      |=> {car_sel_reg, len_sel_reg} == $past(pwdata[7:0]))
    else $error("prescaler selects not stored");
  rsvd_tick_a: assert property (car_sel_reg == iru_pkg::SEL_RSVD |-> !car_tick)
    else $error("reserved select produced a tick");
  phase_swap_a: assert property (tx_mode && car_tick && cg_cnt_reg == phase_len
      && $stable(cfg_reg) ##0 1 |=> cg_phase_reg != $past(cg_phase_reg))
    else $error("carrier phase did not turn");
  car_read_a: assert property (setup_ph && hit_carl |=> prdata[7:6] == 2'h0)
    else $error("low carrier reserved bits not zero");
  count_down_a: assert property (unit_enable_bit && len_tick && lcnt_reg != '0
      && !(wr_ok && hit_lcnt) |=> lcnt_reg == $past(lcnt_reg) - 8'h01)
    else $error("length counter did not step down");
  mask_write_a: assert property (wr_ok && hit_imsk |=> imsk_reg == $past(pwdata[2:0]))
    else $error("mask write not stored");
  flag_sticky_a: assert property (iflg_reg[0] && !(wr_ok && hit_iflg) |=> iflg_reg[0])
    else $error("underflow flag dropped without a clear");
  ufl_flag_a: assert property (ufl_evt |=> iflg_reg[iru_pkg::EVT_UFL_BIT])
    else $error("underflow did not set its flag");
  irq_level_a: assert property (irq == |(iflg_reg & imsk_reg))
    else $error("interrupt level differs from enabled flags");
  rx_follow_a: assert property (rx_mode && $stable(rx_mode) |=> data_reg == $past(rx_level_reg))
    else $error("data bit not following receive level");
  tx_quiet_a: assert property (!tx_mode |=> !ir_tx)
    else $error("transmit pin active outside transmit");
  rsvd_read_a: assert property (setup_ph && hit_cfg |=> prdata[31:2] == 30'h0)
    else $error("reserved configuration bits not zero");

  // Counter reload, edge flags and the underflow flag clear
  ufl_reload_a: assert property (ufl_evt && !(wr_ok && hit_lcnt)
      |=> lcnt_reg == iru_pkg::CNT_WRAP)
    else $error("length counter did not reload after underflow");
  rise_flag_a: assert property (rise_evt |=> iflg_reg[iru_pkg::EVT_RISE_BIT])
    else $error("rising edge did not set its flag");
  fall_flag_a: assert property (fall_evt |=> iflg_reg[iru_pkg::EVT_FALL_BIT])
    else $error("falling edge did not set its flag");
  flag_clear_a: assert property (wr_ok && hit_iflg && pwdata[iru_pkg::EVT_UFL_BIT] && !ufl_evt
      |=> !iflg_reg[iru_pkg::EVT_UFL_BIT])
    else $error("underflow flag not cleared by a one");

  // Pin level paths and refused writes
  tx_level_a: assert property (tx_mode && data_reg && cg_phase_reg |=> ir_tx)
    else $error("transmit pin dark in a lit carrier phase");
  rx_settle_a: assert property (rx_sync_reg[1] == rx_sync_reg[2]
      |=> rx_level_reg == $past(rx_sync_reg[2]))
    else $error("settled receive level not taken");
  wr_refused_a: assert property (psel && penable && pslverr_reg && pwrite
      |=> $stable(cfg_reg) && $stable(imsk_reg))
    else $error("refused write changed a register");

  rx_edge_c: cover property (rx_mode && rise_evt ##[1:200] fall_evt);
  ufl_irq_c: cover property (ufl_evt ##1 irq);
  tx_carrier_c: cover property (tx_mode && ir_tx ##1 !ir_tx ##1 ir_tx);
  clr_race_c: cover property (wr_ok && hit_iflg && |evt_set);
  rsvd_rx_c: cover property (rx_mode && car_sel_reg == iru_pkg::SEL_RSVD && rise_evt);
endmodule // iru_top
`default_nettype wire

// File: sim/iru_ir_partner.sv
// Infrared emitter and receiver stand-in for the remote carrier unit.
// Assumes one clock; the receiver output is a push-pull level.
`timescale 1ns/10ps
`default_nettype none
module iru_ir_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ir_tx,
  input  wire logic       rx_level,
  output logic            ir_rx,
  output logic [7:0]      high_len,
  output logic [7:0]      low_len
);
  logic       tx_q;
  logic [7:0] run;
  // Receiver drives the level it is told to see
  assign ir_rx = rx_level;
  // Emitter records how long each carrier phase stayed lit or dark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q     <= 1'b0;
      run      <= 8'h00;
      high_len <= 8'h00;
      low_len  <= 8'h00;
    end else begin
      tx_q <= ir_tx;
      if (ir_tx != tx_q) begin
        if (tx_q) high_len <= run;
        else low_len <= run;
        run <= 8'h01;
      end else begin
        run <= run + 8'h01;
      end
    end
  end
endmodule // iru_ir_partner
`default_nettype wire

// File: sim/iru_top_tb.sv
// Self-checking bench for the remote carrier unit, driven over APB.
// Assumes pready answers in the first access cycle, as the unit promises.
`timescale 1ns/10ps
`default_nettype none
module iru_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        ir_rx, ir_tx, rx_level;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0]  high_len, low_len;
  logic        err;
  int          fail_count = 0;
  int          tests_run = 0;
  logic [15:0] idx_tab [8];
  logic [7:0]  msk_tab [8];
  iru_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .ir_rx(ir_rx), .ir_tx(ir_tx));
  iru_ir_partner ir (.pclk(pclk), .presetn(presetn), .ir_tx(ir_tx),
    .rx_level(rx_level), .ir_rx(ir_rx), .high_len(high_len), .low_len(low_len));
  // Clock at 200 MHz
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {14'h0, idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait ends once pready is seen high; the watchdog catches a hang
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk8(rd[7:0], exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    print_verdict;
  end
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; rx_level = 1'b0;
    idx_tab = '{iru_pkg::IDX_CFG, iru_pkg::IDX_PSC, iru_pkg::IDX_CARH, iru_pkg::IDX_CARL,
      iru_pkg::IDX_ST, iru_pkg::IDX_LCNT, iru_pkg::IDX_IMSK, iru_pkg::IDX_IFLG};
    msk_tab = '{8'h00, 8'hff, 8'h3f, 8'h3f, 8'h01, 8'hff, 8'h07, 8'h00};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then writable bits against reserved ones
    for (int i = 0; i < 8; i++) rdchk(idx_tab[i], 8'h00);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, idx_tab[i], (i == 0) ? 8'hfc : 8'hff);
      rdchk(idx_tab[i], msk_tab[i]);
      apb(1'b1, idx_tab[i], 8'h00);
    end
    // Unmapped place is refused and reads zero
    apb(1'b0, 16'h5348, 8'h00);
    chk1(err, 1'b1);
    chk8(rd[7:0], 8'h00);
    // Underflow sets its flag; irq only once unmasked; W1C clears
    apb(1'b1, iru_pkg::IDX_LCNT, 8'h03);
    apb(1'b1, iru_pkg::IDX_CFG, 8'h01);
    idle(12);
    rdchk(iru_pkg::IDX_IFLG, 8'h01);
    chk1(irq, 1'b0);
    apb(1'b1, iru_pkg::IDX_IMSK, 8'h01);
    idle(2);
    chk1(irq, 1'b1);
    apb(1'b1, iru_pkg::IDX_CFG, 8'h00);
    apb(1'b1, iru_pkg::IDX_IFLG, 8'h01);
    idle(2);
    chk1(irq, 1'b0);
    rdchk(iru_pkg::IDX_IFLG, 8'h00);
    // Receive with reserved taps: data follows the pin, edges flagged
    apb(1'b1, iru_pkg::IDX_PSC, 8'hff);
    apb(1'b1, iru_pkg::IDX_CFG, 8'h03);
    rx_level <= 1'b1;
    idle(10);
    rdchk(iru_pkg::IDX_ST, 8'h01);
    apb(1'b1, iru_pkg::IDX_ST, 8'h00);
    rdchk(iru_pkg::IDX_ST, 8'h01);
    rx_level <= 1'b0;
    idle(10);
    rdchk(iru_pkg::IDX_ST, 8'h00);
    rdchk(iru_pkg::IDX_IFLG, 8'h06);
    apb(1'b1, iru_pkg::IDX_IMSK, 8'h04);
    idle(2);
    chk1(irq, 1'b1);
    apb(1'b1, iru_pkg::IDX_CFG, 8'h00);
    apb(1'b1, iru_pkg::IDX_IFLG, 8'h07);
    apb(1'b1, iru_pkg::IDX_IMSK, 8'h00);
    // Transmit: carrier at pclk/2, phases of 3 and 2 ticks
    apb(1'b1, iru_pkg::IDX_PSC, 8'h1e);
    apb(1'b1, iru_pkg::IDX_CARH, 8'h02);
    apb(1'b1, iru_pkg::IDX_CARL, 8'h01);
    apb(1'b1, iru_pkg::IDX_ST, 8'h01);
    apb(1'b1, iru_pkg::IDX_CFG, 8'h01);
    apb(1'b1, iru_pkg::IDX_LCNT, 8'h05);
    rdchk(iru_pkg::IDX_LCNT, 8'h05);
    idle(60);
    chk8(high_len, 8'h06);
    chk8(low_len, 8'h04);
    apb(1'b1, iru_pkg::IDX_ST, 8'h00);
    idle(10);
    chk1(ir_tx, 1'b0);
    print_verdict;
  end
endmodule // iru_top_tb
`default_nettype wire
